// [rtl/itp_pkg.sv]
package itp_pkg;

  // Fixed target address on the wire
  localparam logic [6:0] TARGET_ADDR    = 7'h59;
  // Direction bit value meaning read
  localparam logic       RW_READ        = 1'b1;

  // System clock and serial rates
  localparam int         SYS_HZ         = 20_000_000;
  localparam int         SCL_FAST_HZ    = 1_000_000;
  localparam int         SCL_STD_HZ     = 100_000;
  // System cycles per quarter of a serial bit
  localparam int         QUARTER_CYC    = SYS_HZ / (4 * SCL_FAST_HZ);

  // Glitch filter: longest pulse that is blocked
  localparam int         GLITCH_NS      = 50;
  localparam int         LINK_PERIOD_PS = 48_000;
  // Samples a new level must hold; one extra covers sampling phase
  localparam int         FILT_CNT       = (GLITCH_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS + 1;

  // Register file shape and reset contents
  localparam int         REG_COUNT      = 256;
  localparam logic [7:0] REG_RESET      = 8'h00;
  // Default location of read-only bits
  localparam logic [7:0] RO_ADDR_DEF    = 8'h42;
  localparam logic [7:0] RO_MASK_DEF    = 8'h03;

  // Target states, Gray along the usual path
  typedef enum logic [2:0] {
    D_IDLE  = 3'h0,
    D_RX    = 3'h1,
    D_ACK   = 3'h3,
    D_TX    = 3'h2,
    D_TXACK = 3'h6
  } itp_dev_state_t;

  // What the next received byte means
  typedef enum logic [1:0] {
    K_ADDR = 2'h0,
    K_PTR  = 2'h1,
    K_DATA = 2'h3
  } itp_kind_t;

  // Host bus states
  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_START = 3'h1,
    H_BIT   = 3'h3,
    H_WAIT  = 3'h2,
    H_STOP  = 3'h6
  } itp_host_state_t;

  // Host transaction phases
  typedef enum logic [2:0] {
    P_ADDRW = 3'h0,
    P_PTR   = 3'h1,
    P_DATA  = 3'h3,
    P_ADDRR = 3'h2,
    P_RDATA = 3'h6
  } itp_phase_t;

endpackage

// [rtl/itp_link_if.sv]
`timescale 1ns/1ps
interface itp_link_if;
  // Host clock pin drive
  logic hostSclOut;
  logic hostSclOe;
  // Host data pin drive
  logic hostSdaOut;
  logic hostSdaOe;
  // Target data pin drive
  logic devSdaOut;
  logic devSdaOe;
  // Resolved wire levels
  logic scl;
  logic sda;

  // Open drain with pull-ups: any enabled low driver wins
  assign scl = ~(hostSclOe & ~hostSclOut);
  assign sda = ~((hostSdaOe & ~hostSdaOut) | (devSdaOe & ~devSdaOut));

  modport target (input scl, input sda, output devSdaOut, output devSdaOe);
  modport host (input sda, output hostSclOut, output hostSclOe, output hostSdaOut, output hostSdaOe);
endinterface

// [rtl/itp_target.sv]
`timescale 1ns/1ps
module itp_target #(
  parameter logic [7:0] RO_ADDR = itp_pkg::RO_ADDR_DEF,
  parameter logic [7:0] RO_MASK = itp_pkg::RO_MASK_DEF
) (
  input  wire logic        sys_clk,
  input  wire logic        linkClk,
  input  wire logic        rst,
  itp_link_if.target       link,
  output logic             wrValid,
  output logic [7:0]       wrAddr,
  output logic [7:0]       wrData
);

  // Link-side state, all on linkClk
  typedef struct packed {
    logic [1:0]              sclSync;  // Pin synchroniser
    logic [1:0]              sdaSync;  // Pin synchroniser
    logic                    sclF;     // Filtered clock
    logic [3:0]              sclCnt;   // Clock filter count
    logic                    sdaF;     // Filtered data
    logic [3:0]              sdaCnt;   // Data filter count
    itp_pkg::itp_dev_state_t st;       // Protocol state
    itp_pkg::itp_kind_t      kind;     // Meaning of next byte
    logic [3:0]              bitCnt;   // Bits in current byte
    logic [7:0]              shift;    // Byte shifter
    logic                    rw;       // Latched direction
    logic                    ackOk;    // Host acked a read byte
    logic [7:0]              ptr;      // Register pointer
    logic                    sdaLow;   // Pull data low
    logic                    evTog;    // Toggles per stored byte
    logic [7:0]              evAddr;   // Last stored address
    logic [7:0]              evData;   // Last stored byte
  } itp_link_state_t;

  // System-side state, all on sys_clk
  typedef struct packed {
    logic [2:0]              tg;       // Toggle sync plus edge stage
    logic                    wrValid;  // Event pulse
    logic [7:0]              wrAddr;   // Captured address
    logic [7:0]              wrData;   // Captured byte
  } itp_sys_state_t;

  itp_link_state_t lnk;                // Link registers
  itp_link_state_t next_lnk;           // Link next value
  itp_sys_state_t  sy;                 // System registers
  itp_sys_state_t  next_sy;            // System next value

  logic [7:0]      mem [itp_pkg::REG_COUNT];  // Register file
  logic            memWe;              // Store strobe
  logic [7:0]      memAddr;            // Store address
  logic [7:0]      memData;            // Store value
  logic [7:0]      roMask;             // Protected bits of target
  logic [7:0]      rdByte;             // Byte at pointer
  logic            sclRise;            // Filtered clock rose
  logic            sclFall;            // Filtered clock fell
  logic            startSeen;          // Start or restart
  logic            stopSeen;           // Stop
  logic            loadTx;             // Fetch next read byte

  // One filter step: new level only after FILT_CNT differing samples
  function automatic logic [4:0] filt_step(input logic raw, input logic val, input logic [3:0] cnt);
    logic [4:0] res;
    res = {val, 4'h0};
    if (raw != val) begin
      if (cnt == 4'(itp_pkg::FILT_CNT - 1)) begin
        res = {raw, 4'h0};
      end else begin
        res = {val, cnt + 4'h1};
      end
    end
    return res;
  endfunction

  assign rdByte = mem[lnk.ptr];

  // Link protocol engine
  always_comb begin
    next_lnk = lnk;
    memWe = 1'b0;
    memAddr = lnk.ptr;
    memData = lnk.shift;
    loadTx = 1'b0;
    // pins pass two flops, rate free
    next_lnk.sclSync = {lnk.sclSync[0], link.scl};
    next_lnk.sdaSync = {lnk.sdaSync[0], link.sda};
    {next_lnk.sclF, next_lnk.sclCnt} = filt_step(lnk.sclSync[1], lnk.sclF, lnk.sclCnt);
    {next_lnk.sdaF, next_lnk.sdaCnt} = filt_step(lnk.sdaSync[1], lnk.sdaF, lnk.sdaCnt);
    // Equal filter delay on both lines keeps their order intact
    sclRise = next_lnk.sclF & ~lnk.sclF;
    sclFall = ~next_lnk.sclF & lnk.sclF;
    startSeen = lnk.sclF & next_lnk.sclF & lnk.sdaF & ~next_lnk.sdaF;
    stopSeen = lnk.sclF & next_lnk.sclF & ~lnk.sdaF & next_lnk.sdaF;
    if (stopSeen) begin
      next_lnk.st = itp_pkg::D_IDLE;
      next_lnk.sdaLow = 1'b0;
    end else if (startSeen) begin
      next_lnk.st = itp_pkg::D_RX;
      next_lnk.kind = itp_pkg::K_ADDR;
      next_lnk.bitCnt = 4'h0;
      next_lnk.sdaLow = 1'b0;
    end else begin
      case (lnk.st)
        itp_pkg::D_IDLE: begin
          next_lnk.sdaLow = 1'b0;
        end
        itp_pkg::D_RX: begin
          if (sclRise) begin
            next_lnk.shift = {lnk.shift[6:0], lnk.sdaF};
            next_lnk.bitCnt = lnk.bitCnt + 4'h1;
          end else if (sclFall && lnk.bitCnt == 4'h8) begin
            next_lnk.bitCnt = 4'h0;
            case (lnk.kind)
              itp_pkg::K_ADDR: begin
                if (lnk.shift[7:1] == itp_pkg::TARGET_ADDR) begin
                  next_lnk.rw = lnk.shift[0];
                  next_lnk.kind = itp_pkg::K_PTR;
                  next_lnk.sdaLow = 1'b1;
                  next_lnk.st = itp_pkg::D_ACK;
                end else begin
                  next_lnk.st = itp_pkg::D_IDLE;
                end
              end
              itp_pkg::K_PTR: begin
                next_lnk.ptr = lnk.shift;
                next_lnk.kind = itp_pkg::K_DATA;
                next_lnk.sdaLow = 1'b1;
                next_lnk.st = itp_pkg::D_ACK;
              end
              default: begin
                memWe = 1'b1;
                next_lnk.ptr = lnk.ptr + 8'h01;
                next_lnk.evTog = ~lnk.evTog;
                next_lnk.evAddr = lnk.ptr;
                next_lnk.evData = lnk.shift;
                next_lnk.sdaLow = 1'b1;
                next_lnk.st = itp_pkg::D_ACK;
              end
            endcase
          end
        end
        itp_pkg::D_ACK: begin
          if (sclFall) begin
            if (lnk.rw == itp_pkg::RW_READ && lnk.kind == itp_pkg::K_PTR) begin
              loadTx = 1'b1;
            end else begin
              next_lnk.sdaLow = 1'b0;
              next_lnk.st = itp_pkg::D_RX;
            end
          end
        end
        itp_pkg::D_TX: begin
          if (sclFall) begin
            if (lnk.bitCnt == 4'h8) begin
              next_lnk.sdaLow = 1'b0;
              next_lnk.ackOk = 1'b0;
              next_lnk.st = itp_pkg::D_TXACK;
            end else begin
              next_lnk.sdaLow = ~lnk.shift[7];
              next_lnk.shift = {lnk.shift[6:0], 1'b0};
              next_lnk.bitCnt = lnk.bitCnt + 4'h1;
            end
          end
        end
        itp_pkg::D_TXACK: begin
          if (sclRise) begin
            if (lnk.sdaF) begin
              next_lnk.st = itp_pkg::D_IDLE;
            end else begin
              next_lnk.ackOk = 1'b1;
            end
          end else if (sclFall && lnk.ackOk) begin
            loadTx = 1'b1;
          end
        end
        default: begin
          next_lnk.st = itp_pkg::D_IDLE;
        end
      endcase
    end
    // Drive MSB of the byte at the pointer
    if (loadTx) begin
      next_lnk.sdaLow = ~rdByte[7];
      next_lnk.shift = {rdByte[6:0], 1'b0};
      next_lnk.bitCnt = 4'h1;
      next_lnk.ptr = lnk.ptr + 8'h01;
      next_lnk.st = itp_pkg::D_TX;
    end
  end

  // Link state register
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      lnk <= '{sclSync: 2'h3, sdaSync: 2'h3, sclF: 1'b1, sdaF: 1'b1,
               st: itp_pkg::D_IDLE, kind: itp_pkg::K_ADDR, default: '0};
    end else begin
      lnk <= next_lnk;
    end
  end

  assign roMask = (memAddr == RO_ADDR) ? RO_MASK : 8'h00;

  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < itp_pkg::REG_COUNT; i++) begin
        mem[i] <= itp_pkg::REG_RESET;
      end
    end else if (memWe) begin
      mem[memAddr] <= (mem[memAddr] & roMask) | (memData & ~roMask);
    end
  end

  // Store events cross by toggle; address and data change with it and are stable long before it is seen
  always_comb begin
    next_sy = sy;
    next_sy.tg = {sy.tg[1:0], lnk.evTog};
    next_sy.wrValid = sy.tg[2] ^ sy.tg[1];
    if (sy.tg[2] ^ sy.tg[1]) begin
      next_sy.wrAddr = lnk.evAddr;
      next_sy.wrData = lnk.evData;
    end
  end

  // System state register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sy <= '0;
    end else begin
      sy <= next_sy;
    end
  end

  // Pin and user outputs
  assign link.devSdaOut = 1'b0;
  assign link.devSdaOe  = lnk.sdaLow;
  assign wrValid        = sy.wrValid;
  assign wrAddr         = sy.wrAddr;
  assign wrData         = sy.wrData;

endmodule

// [rtl/itp_host.sv]
`timescale 1ns/1ps
module itp_host #(
  parameter int QUARTER = itp_pkg::QUARTER_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  itp_link_if.host         link,
  input  wire logic        cmdValid,
  output logic             cmdReady,
  input  wire logic        cmdRead,
  input  wire logic [7:0]  cmdPtr,
  input  wire logic [7:0]  cmdLen,
  input  wire logic        wrValid,
  output logic             wrReady,
  input  wire logic [7:0]  wrByte,
  output logic             rdValid,
  output logic [7:0]       rdByte,
  output logic             done,
  output logic             nack
);

  // Whole host state
  typedef struct packed {
    itp_pkg::itp_host_state_t st;      // Bus state
    itp_pkg::itp_phase_t      phase;   // Byte role
    logic [1:0]               q;       // Quarter of bit
    logic [7:0]               tick;    // Quarter countdown
    logic [3:0]               bitCnt;  // Bit of nine
    logic [8:0]               tx;      // Byte plus ack slot out
    logic [8:0]               rx;      // Sampled bits
    logic [7:0]               left;    // Data bytes left
    logic                     rd;      // Read transaction
    logic [7:0]               ptr;     // Pointer to send
    logic                     sclLow;  // Pull clock low
    logic                     sdaLow;  // Pull data low
    logic [1:0]               sdaSync; // Pin synchroniser
    logic                     rdValid; // Read byte pulse
    logic [7:0]               rdByte;  // Read byte
    logic                     done;    // End pulse
    logic                     nack;    // Refused by target
  } itp_host_reg_t;

  itp_host_reg_t    r;                 // Registers
  itp_host_reg_t    next_r;            // Next value
  logic             qEnd;              // Quarter finished
  logic             byteEnd;           // Ninth bit finished
  logic             ack;               // Ack slot seen low

  // Bus sequencer
  always_comb begin
    next_r = r;
    byteEnd = 1'b0;
    ack = ~r.rx[0];
    next_r.sdaSync = {r.sdaSync[0], link.sda};
    next_r.rdValid = 1'b0;
    next_r.done = 1'b0;
    qEnd = (r.tick == 8'h00);
    if (r.st != itp_pkg::H_IDLE && r.st != itp_pkg::H_WAIT) begin
      if (qEnd) begin
        next_r.tick = 8'(QUARTER - 1);
        next_r.q = r.q + 2'h1;
      end else begin
        next_r.tick = r.tick - 8'h01;
      end
    end
    case (r.st)
      itp_pkg::H_IDLE: begin
        if (cmdValid) begin
          // begin with address and write bit
          next_r.st = itp_pkg::H_START;
          next_r.phase = itp_pkg::P_ADDRW;
          next_r.rd = cmdRead;
          next_r.ptr = cmdPtr;
          next_r.left = (cmdLen == 8'h00) ? 8'h01 : cmdLen;
          next_r.tx = {itp_pkg::TARGET_ADDR, ~itp_pkg::RW_READ, 1'b1};
          next_r.q = 2'h0;
          next_r.tick = 8'(QUARTER - 1);
          next_r.nack = 1'b0;
        end
      end
      itp_pkg::H_START: begin
        if (qEnd) begin
          case (r.q)
            2'h0: next_r.sdaLow = 1'b0;
            2'h1: next_r.sclLow = 1'b0;
            2'h2: next_r.sdaLow = 1'b1;
            default: begin
              next_r.sclLow = 1'b1;
              next_r.bitCnt = 4'h0;
              next_r.st = itp_pkg::H_BIT;
            end
          endcase
        end
      end
      itp_pkg::H_BIT: begin
        // data set a quarter after clock falls
        if (qEnd) begin
          case (r.q)
            2'h0: next_r.sdaLow = ~r.tx[8];
            2'h1: next_r.sclLow = 1'b0;
            2'h2: next_r.rx = {r.rx[7:0], r.sdaSync[1]};
            default: begin
              next_r.sclLow = 1'b1;
              next_r.tx = {r.tx[7:0], 1'b1};
              next_r.bitCnt = r.bitCnt + 4'h1;
              byteEnd = (r.bitCnt == 4'h8);
            end
          endcase
        end
      end
      itp_pkg::H_WAIT: begin
        // bytes go out in arrival order
        if (wrValid) begin
          next_r.tx = {wrByte, 1'b1};
          next_r.bitCnt = 4'h0;
          next_r.q = 2'h0;
          next_r.tick = 8'(QUARTER - 1);
          next_r.st = itp_pkg::H_BIT;
        end
      end
      itp_pkg::H_STOP: begin
        if (qEnd) begin
          case (r.q)
            2'h0: next_r.sdaLow = 1'b1;
            2'h1: next_r.sclLow = 1'b0;
            2'h2: next_r.sdaLow = 1'b0;
            default: begin
              next_r.done = 1'b1;
              next_r.st = itp_pkg::H_IDLE;
            end
          endcase
        end
      end
      default: begin
        next_r.st = itp_pkg::H_IDLE;
      end
    endcase
    // Decide what follows each finished byte
    if (byteEnd) begin
      next_r.bitCnt = 4'h0;
      case (r.phase)
        itp_pkg::P_ADDRW: begin
          next_r.phase = itp_pkg::P_PTR;
          next_r.tx = {r.ptr, 1'b1};
        end
        itp_pkg::P_PTR: begin
          if (r.rd) begin
            next_r.phase = itp_pkg::P_ADDRR;
            next_r.tx = {itp_pkg::TARGET_ADDR, itp_pkg::RW_READ, 1'b1};
            next_r.st = itp_pkg::H_START;
          end else begin
            next_r.phase = itp_pkg::P_DATA;
            next_r.st = itp_pkg::H_WAIT;
          end
        end
        itp_pkg::P_DATA: begin
          // stop on tenth pulse after last ack
          if (r.left == 8'h01) begin
            next_r.st = itp_pkg::H_STOP;
          end else begin
            next_r.left = r.left - 8'h01;
            next_r.st = itp_pkg::H_WAIT;
          end
        end
        itp_pkg::P_ADDRR: begin
          next_r.phase = itp_pkg::P_RDATA;
          next_r.tx = {8'hff, r.left == 8'h01};
        end
        default: begin
          next_r.rdValid = 1'b1;
          next_r.rdByte = r.rx[8:1];
          if (r.left == 8'h01) begin
            next_r.st = itp_pkg::H_STOP;
          end else begin
            next_r.left = r.left - 8'h01;
            next_r.tx = {8'hff, r.left == 8'h02};
          end
        end
      endcase
      // missing ack on a sent byte aborts
      if (!ack && r.phase != itp_pkg::P_RDATA) begin
        next_r.nack = 1'b1;
        next_r.st = itp_pkg::H_STOP;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      r <= '{st: itp_pkg::H_IDLE, phase: itp_pkg::P_ADDRW, sdaSync: 2'h3, default: '0};
    end else begin
      r <= next_r;
    end
  end

  // Pins and user outputs
  assign link.hostSclOut = 1'b0;
  assign link.hostSclOe  = r.sclLow;
  assign link.hostSdaOut = 1'b0;
  assign link.hostSdaOe  = r.sdaLow;
  assign cmdReady        = (r.st == itp_pkg::H_IDLE);
  assign wrReady         = (r.st == itp_pkg::H_WAIT);
  assign rdValid         = r.rdValid;
  assign rdByte          = r.rdByte;
  assign done            = r.done;
  assign nack            = r.nack;

endmodule

// [test/itp_link_assertions.sv]
`timescale 1ns/1ps
module itp_link_assertions #(
  parameter int QUARTER = 5
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hostSclOut,
  input wire logic hostSclOe,
  input wire logic hostSdaOut,
  input wire logic hostSdaOe,
  input wire logic devSdaOut,
  input wire logic devSdaOe,
  input wire logic scl,
  input wire logic sda
);
  // Longest wait from start to clock low
  localparam int QSPAN = 2 * QUARTER;
  // Decoder state
  logic       sclQ, sdaQ, isAddr, isRead, sel, nackR;
  logic [3:0] bitCnt;
  logic [7:0] shiftR;
  // Clock rise, ninth slot, address hit
  wire        rise = !sclQ && scl;
  wire        ack9 = rise && bitCnt == 4'h8;
  wire        match = shiftR[7:1] == itp_pkg::TARGET_ADDR;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Frame tracker; a start anywhere restarts address reception
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {sclQ, sdaQ, isAddr, isRead, sel, nackR, bitCnt, shiftR} <= {2'b11, 4'h0, 4'h0, 8'h00};
    end else begin
      sclQ <= scl;
      sdaQ <= sda;
      if (sclQ && scl && sdaQ && !sda) begin
        {isAddr, isRead, nackR, bitCnt} <= {3'b100, 4'h0};
      end else if (sclQ && scl && !sdaQ && sda) begin
        sel <= 1'b0;
      end else if (ack9) begin
        bitCnt <= 4'h0;
        isAddr <= 1'b0;
        if (isAddr) begin
          sel <= match;
          isRead <= shiftR[0];
        end
        // Slot left high after a read byte
        if (!isAddr && isRead && sda) begin
          nackR <= 1'b1;
        end
      end else if (rise) begin
        bitCnt <= bitCnt + 4'h1;
        shiftR <= {shiftR[6:0], sda};
      end
    end
  end

  property p_devLow; $changed(devSdaOe) |-> !scl; endproperty
  a_devLow: assert property (p_devLow) else $error("target moved data with clock high");
  property p_addrAck; ack9 && isAddr |-> sda == !match; endproperty
  a_addrAck: assert property (p_addrAck) else $error("address ack wrong");
  property p_wrAck; ack9 && !isAddr && sel && !isRead |-> !sda; endproperty
  a_wrAck: assert property (p_wrAck) else $error("write byte not acked");
  property p_rdSlot; ack9 && !isAddr && sel && isRead |-> !devSdaOe; endproperty
  a_rdSlot: assert property (p_rdSlot) else $error("target held host ack slot");
  property p_nackIdle; nackR |-> !devSdaOe; endproperty
  a_nackIdle: assert property (p_nackIdle) else $error("target drove after nack");
  property p_start; $rose(hostSdaOe) && !hostSclOe |-> ##[1:QSPAN] hostSclOe; endproperty
  a_start: assert property (p_start) else $error("start not followed by clock low");
  property p_stop; $fell(hostSdaOe) && !hostSclOe |-> ##1 (!hostSclOe && !hostSdaOe)[*4]; endproperty
  a_stop: assert property (p_stop) else $error("bus not idle after stop");
  property p_openDrain; !(hostSclOut || hostSdaOut || devSdaOut); endproperty
  a_openDrain: assert property (p_openDrain) else $error("line driven high");

  c_wrAck: cover property (ack9 && sel && !isRead && !isAddr);
  c_rdAddr: cover property (ack9 && isAddr && shiftR[0]);
  c_nack: cover property ($rose(nackR));
endmodule

// [test/tb_i2c_target_register_port.sv]
`timescale 1ns/1ps
module tb_i2c_target_register_port;
  logic       sys_clk = 1'b0, linkClk = 1'b0, rst = 1'b1;
  logic       cmdValid = 1'b0, cmdRead = 1'b0, wrValid = 1'b0;
  logic [7:0] cmdPtr = 8'h00, cmdLen = 8'h00, wrByte = 8'h00;
  logic       cmdReady, wrReady, rdValid, done, nack, tWr, heard;
  logic [7:0] rdByte, tAddr, tData;
  logic [7:0] wq[$], eq[$], rq[$];
  int         errors = 0, cmp_count = 0, cyc = 0, wrCnt = 0, qLen = 5;

  itp_link_if link ();
  // Second bus, bit-banged with faults
  itp_link_if link2 ();

  always #25 sys_clk = ~sys_clk;
  always #24 linkClk = ~linkClk;

  itp_host i_itp_host (.sys_clk, .rst, .link(link.host), .cmdValid, .cmdReady, .cmdRead, .cmdPtr, .cmdLen,
    .wrValid, .wrReady, .wrByte, .rdValid, .rdByte, .done, .nack);
  itp_target i_itp_target (.sys_clk, .linkClk, .rst, .link(link.target), .wrValid(tWr), .wrAddr(tAddr),
    .wrData(tData));
  itp_target i_itp_target_b (.sys_clk, .linkClk, .rst, .link(link2.target), .wrValid(), .wrAddr(), .wrData());
  itp_link_assertions i_itp_link_assertions (.sys_clk, .rst, .hostSclOut(link.hostSclOut),
    .hostSclOe(link.hostSclOe), .hostSdaOut(link.hostSdaOut), .hostSdaOe(link.hostSdaOe),
    .devSdaOut(link.devSdaOut), .devSdaOe(link.devSdaOe), .scl(link.scl), .sda(link.sda));

  // Cycle limit, write events, second target activity
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (tWr) wrCnt <= wrCnt + 1;
    if (link2.devSdaOe) heard <= 1'b1;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask

  // One host transaction; write bytes from wq, read bytes into rq
  task automatic xfer(input logic rd, input logic [7:0] p, n);
    int k;
    k = 0;
    rq.delete();
    @(posedge sys_clk);
    cmdValid <= 1'b1;
    cmdRead <= rd;
    cmdPtr <= p;
    cmdLen <= n;
    wrValid <= !rd;
    wrByte <= rd ? 8'h00 : wq[0];
    @(posedge sys_clk);
    cmdValid <= 1'b0;
    do begin
      @(negedge sys_clk);
      if (rdValid) rq.push_back(rdByte);
      if (wrValid && wrReady) begin
        k++;
        @(posedge sys_clk);
        wrValid <= k < n;
        wrByte <= k < n ? wq[k] : 8'h00;
      end
    end while (!done);
  endtask

  // Write wq at p, read it back against eq
  task automatic rt(input logic [7:0] p, n);
    int w;
    w = wrCnt;
    xfer(1'b0, p, n);
    chk({7'h0, nack}, 8'h00, "write nack");
    chk({7'h0, cmdReady}, 8'h01, "ready after write");
    chk(8'(wrCnt - w), n, "write count");
    chk(tAddr, p + n - 8'h01, "last address");
    chk(tData, wq[n-1], "last data");
    xfer(1'b1, p, n);
    for (int i = 0; i < n; i++) chk(rq[i], eq[i], "read back");
  endtask

  // Quarter of a bit: 5 cycles at 1 MHz, 50 at 100 kHz
  task automatic q();
    repeat (qLen) @(posedge sys_clk);
  endtask

  task automatic bit2(input logic b, g, output logic s);
    link2.hostSdaOe <= !b;
    q();
    link2.hostSclOe <= 1'b0;
    // 20 ns dips on both lines, under the filter
    if (g) begin
      link2.hostSclOe <= #40 1'b1;
      link2.hostSclOe <= #60 1'b0;
      link2.hostSdaOe <= #100 b;
      link2.hostSdaOe <= #120 !b;
    end
    q();
    s = link2.sda;
    q();
    link2.hostSclOe <= 1'b1;
    q();
  endtask

  task automatic start2();
    link2.hostSdaOe <= 1'b0;
    q();
    link2.hostSclOe <= 1'b0;
    q();
    link2.hostSdaOe <= 1'b1;
    q();
    link2.hostSclOe <= 1'b1;
    q();
  endtask

  task automatic stop2();
    link2.hostSdaOe <= 1'b1;
    q();
    link2.hostSclOe <= 1'b0;
    q();
    link2.hostSdaOe <= 1'b0;
    q();
  endtask

  task automatic sendB(input logic [7:0] d, input logic g, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) bit2(d[i], g, s);
    bit2(1'b1, 1'b0, a);
  endtask

  initial begin
    logic a;
    {link2.hostSclOut, link2.hostSdaOut, link2.hostSclOe, link2.hostSdaOe} = 4'h0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (8) @(posedge sys_clk);
    xfer(1'b1, 8'h80, 8'h01);
    chk(rq[0], 8'h00, "reset value");
    $display("test reset done");
    // Numerator word, high byte first
    wq = '{8'h2b, 8'h81, 8'h3c, 8'hd4, 8'h0e, 8'h95};
    eq = wq;
    rt(8'h1b, 8'h06);
    // Zero length still reads one byte
    xfer(1'b1, 8'h1b, 8'h00);
    chk(rq[0], 8'h2b, "zero length read");
    chk({7'h0, cmdReady}, 8'h01, "ready after read");
    $display("test block done");
    wq = '{8'h11, 8'h22};
    eq = wq;
    rt(8'hff, 8'h02);
    $display("test wrap done");
    wq = '{8'hff, 8'h5a};
    eq = '{8'hfc, 8'h5a};
    rt(8'h42, 8'h02);
    $display("test read-only done");
    // Partial byte, restart, glitched address
    start2();
    repeat (3) bit2(1'b1, 1'b0, a);
    start2();
    sendB(8'hb2, 1'b1, a);
    chk({7'h0, a}, 8'h00, "address ack");
    stop2();
    @(posedge sys_clk);
    heard <= 1'b0;
    start2();
    sendB(8'hb0, 1'b0, a);
    sendB(8'h00, 1'b0, a);
    chk({7'h0, heard}, 8'h00, "foreign address answered");
    stop2();
    $display("test bit-bang done");
    // Standard mode rate, address and ack
    qLen = 50;
    start2();
    sendB(8'hb2, 1'b0, a);
    chk({7'h0, a}, 8'h00, "slow address ack");
    stop2();
    $display("test standard mode done");
    summarize();
  end
endmodule
